// ==== verilog/smbus_slave_alert_gpio.sv ====
// two-wire slave with alert response, fault logs and general pins
// Notes on behaviour
// - command byte low five bits load pointer
// - first data byte acked and stored
// - second write data byte acked, then dropped
// - read address acked, pointed register sent
// - master ack repeats the same byte
// - pointer survives end of transaction
// - enabled fault pulls notification line low
// - alert address read answered with own address
// - lowest address wins, loser stops sending
// - winner releases line, losers keep holding
// - flag shows line active, zero write releases
// - reassert only on new or recurring fault
// - set fault bit blocks further notification of its kind
// - same kind set elsewhere blocks notification
// - three pin level bits are read only
// - three bits drive open-drain pin pulldowns
// - two bits pick measured pin
// - first pin toggle sets change flag
// - enabled change flag raises notification
// - address top bits fixed 01, rest strapped
// - broadcast writes accepted unless masked
`timescale 1ns/1ps
module smbus_slave_alert_gpio (
	input  logic                       sys_clk_i,
	input  logic                       srst_i,
	input  logic                       link_clk_i,
	input  logic                       scl_i,
	output logic                       scl_o,
	output logic                       scl_oe_o,
	input  logic                       sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_o,
	input  logic [4:0]                 addr_strap_i,
	input  smbus_alert_pkg::fault_evt_t fault_evt_i,
	input  logic [2:0]                 gpio_i,
	output logic [2:0]                 gpio_o,
	output logic [2:0]                 gpio_oe_o,
	output logic [1:0]                 meas_sel_o,
	output logic                       alert_o,
	output logic                       alert_oe_o
);
	typedef enum {L_IDLE, L_ADDR, L_CMD, L_WDATA, L_WDISC, L_ACK,
		L_WAIT, L_TX, L_MACK} link_state_t;

	link_state_t               state;
	link_state_t               ret;
	logic [1:0]                lrst_s;
	logic                      lrst;
	logic [2:0]                scl_s;
	logic [2:0]                sda_s;
	logic [4:0]                strap_s0;
	logic [4:0]                strap_s1;
	logic [1:0]                notify_s;
	logic [1:0]                bcast_s;
	logic [1:0]                ack_s;
	logic [3:0]                bitcnt;
	logic [7:0]                shreg;
	logic [7:0]                txbyte;
	logic [4:0]                ptr;
	logic                      sda_drv;
	logic                      scl_hold;
	logic                      ara;
	logic                      more;
	logic                      req_tog;
	logic                      win_tog;
	smbus_alert_pkg::xfer_req_t req;
	logic [6:0]                own_addr;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      start;
	logic                      stop;
	logic                      pend;
	logic                      byte_end;
	logic                      cmd_load;
	logic [4:0]                cmd_low;
	logic [2:0]                rq_s;
	logic [2:0]                win_s;
	logic [2:0]                gpin_s0;
	logic [2:0]                gpin_s1;
	logic                      pin1_prev;
	logic                      rq_evt;
	logic                      win_evt;
	logic                      wr_en;
	logic                      ack_tog;
	logic [7:0]                rd_word;
	logic [7:0]                rd_mux;
	logic [7:0]                cfg;
	logic [7:0]                ctl;
	logic [7:0]                flt1;
	logic [7:0]                flt2;
	logic [7:0]                gpin;
	logic                      notify;
	logic                      pin_toggle;
	logic                      trig;
	logic                      wr_cfg;
	logic                      wr_gpin;

	// ****************************************
	// link side crossings
	// ****************************************
	always_ff @(posedge link_clk_i) begin
		lrst_s   <= {lrst_s[0], srst_i};
		scl_s    <= {scl_s[1:0], scl_i};
		sda_s    <= {sda_s[1:0], sda_i};
		strap_s0 <= addr_strap_i;
		strap_s1 <= strap_s0;
		notify_s <= {notify_s[0], notify};
		bcast_s  <= {bcast_s[0], ctl[smbus_alert_pkg::CTL_BCAST_EN]};
		ack_s    <= {ack_s[0], ack_tog};
	end

	assign lrst     = lrst_s[1];
	assign own_addr = {smbus_alert_pkg::ADDR_FIXED_MSBS, strap_s1};
	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start    = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	assign stop     = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
	assign pend     = req_tog != ack_s[1];
	assign byte_end = scl_fall && bitcnt == smbus_alert_pkg::BYTE_BITS;
	assign cmd_load = state == L_CMD && byte_end;
	assign cmd_low  = shreg[4:0];

	// ****************************************
	// link state machine
	// ****************************************
	// a new start aborts anything, so a lost frame cannot wedge the slave
	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			state    <= L_IDLE;
			ret      <= L_IDLE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			txbyte   <= 8'h00;
			ptr      <= 5'h00;
			sda_drv  <= 1'b0;
			scl_hold <= 1'b0;
			ara      <= 1'b0;
			more     <= 1'b0;
			req_tog  <= 1'b0;
			win_tog  <= 1'b0;
			req      <= '0;
		end else if (start) begin
			state    <= L_ADDR;
			bitcnt   <= 4'h0;
			sda_drv  <= 1'b0;
			scl_hold <= 1'b0;
		end else if (stop) begin
			state    <= L_IDLE;
			sda_drv  <= 1'b0;
			scl_hold <= 1'b0;
		end else begin
			unique case (state)
			L_IDLE: begin
			end
			L_ADDR, L_CMD, L_WDATA, L_WDISC: begin
				if (scl_rise) begin
					shreg  <= {shreg[6:0], sda_s[1]};
					bitcnt <= bitcnt + 4'h1;
				end else if (byte_end) begin
					bitcnt  <= 4'h0;
					sda_drv <= 1'b1;
					state   <= L_ACK;
					if (state == L_ADDR) begin
						if (shreg[7:1] == own_addr) begin
							ara <= 1'b0;
							ret <= shreg[0] ? L_WAIT : L_CMD;
							if (shreg[0]) begin
								req <= '{wr: 1'b0, ptr: ptr, data: 8'h00};
								req_tog <= ~req_tog;
							end
						end else if (shreg == {smbus_alert_pkg::BCAST_ADDR, 1'b0}
							&& bcast_s[1]) begin
							ara <= 1'b0;
							ret <= L_CMD;
						end else if (shreg == {smbus_alert_pkg::ARA_ADDR, 1'b1}
							&& notify_s[1]) begin
							ara    <= 1'b1;
							ret    <= L_TX;
							txbyte <= {own_addr, 1'b0};
						end else begin
							sda_drv <= 1'b0;
							state   <= L_IDLE;
						end
					end else if (state == L_CMD) begin
						ptr <= shreg[4:0];
						ret <= L_WDATA;
					end else if (state == L_WDATA) begin
						req <= '{wr: 1'b1, ptr: ptr, data: shreg};
						req_tog <= ~req_tog;
						ret <= L_WDISC;
					end else begin
						ret <= L_WDISC;
					end
				end
			end
			L_ACK: begin
				if (scl_fall) begin
					state    <= ret;
					scl_hold <= ret == L_WAIT;
					shreg    <= txbyte;
					sda_drv  <= ret == L_TX ? ~txbyte[7] : 1'b0;
				end
			end
			L_WAIT: begin
				// data is set here and scl let go one link cycle later
				if (!pend) begin
					txbyte  <= rd_word;
					shreg   <= rd_word;
					sda_drv <= ~rd_word[7];
					state   <= L_TX;
				end
			end
			L_TX: begin
				scl_hold <= 1'b0;
				if (scl_rise) begin
					bitcnt <= bitcnt + 4'h1;
					if (ara && !sda_drv && !sda_s[1]) begin
						state <= L_IDLE;
					end else if (ara && bitcnt == smbus_alert_pkg::LAST_BIT) begin
						win_tog <= ~win_tog;
					end
				end else if (byte_end) begin
					bitcnt  <= 4'h0;
					sda_drv <= 1'b0;
					state   <= L_MACK;
				end else if (scl_fall) begin
					shreg   <= {shreg[6:0], 1'b0};
					sda_drv <= ~shreg[6];
				end
			end
			L_MACK: begin
				if (scl_rise) begin
					more <= ~sda_s[1];
				end else if (scl_fall) begin
					if (more && !ara) begin
						state   <= L_TX;
						shreg   <= txbyte;
						sda_drv <= ~txbyte[7];
					end else begin
						state <= L_IDLE;
					end
				end
			end
			endcase
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_drv;
	assign scl_o    = 1'b0;
	assign scl_oe_o = scl_hold;

	// ****************************************
	// core side crossings
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rq_s      <= 3'h0;
			win_s     <= 3'h0;
		end else begin
			rq_s      <= {rq_s[1:0], req_tog};
			win_s     <= {win_s[1:0], win_tog};
		end
	end

	// pin chain runs through reset, so a high pin gives no false toggle
	always_ff @(posedge sys_clk_i) begin
		gpin_s0   <= gpio_i;
		gpin_s1   <= gpin_s0;
		pin1_prev <= gpin_s1[0];
	end

	assign rq_evt     = rq_s[1] ^ rq_s[2];
	assign win_evt    = win_s[1] ^ win_s[2];
	assign wr_en      = rq_evt & req.wr;
	assign wr_cfg     = wr_en && req.ptr == smbus_alert_pkg::REG_ALERT_CFG;
	assign wr_gpin    = wr_en
		&& req.ptr == smbus_alert_pkg::REG_GENERAL_PIN_CONTROL;
	assign pin_toggle = gpin_s1[0] ^ pin1_prev;

	// payload stays still while the toggle is in flight
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ack_tog <= 1'b0;
			rd_word <= 8'h00;
		end else if (rq_evt) begin
			ack_tog <= rq_s[1];
			if (!req.wr) begin
				rd_word <= rd_mux;
			end
		end
	end

	always_comb begin
		case (req.ptr)
		smbus_alert_pkg::REG_ALERT_CFG: begin
			rd_mux = cfg;
			rd_mux[smbus_alert_pkg::CFG_NOTIFY] = notify;
		end
		smbus_alert_pkg::REG_CONTROL: rd_mux = ctl;
		smbus_alert_pkg::REG_FAULT_LOG_ONE: rd_mux = flt1;
		smbus_alert_pkg::REG_FAULT_LOG_TWO: rd_mux = flt2;
		smbus_alert_pkg::REG_GENERAL_PIN_CONTROL: begin
			rd_mux = {gpin[7:3], gpin_s1};
		end
		default: rd_mux = 8'h00;
		endcase
	end

	// ****************************************
	// registers and notification
	// ****************************************
	// a kind alerts only when its whole log field was empty
	assign trig =
		(|fault_evt_i.uv && ~|flt1[3:0] && cfg[smbus_alert_pkg::CFG_UV_EN])
		| (|fault_evt_i.oc && ~|flt1[7:4] && cfg[smbus_alert_pkg::CFG_OC_EN])
		| (|fault_evt_i.pb && ~|flt2[3:0] && cfg[smbus_alert_pkg::CFG_PB_EN])
		| (pin_toggle && !flt2[smbus_alert_pkg::FT2_PIN1_CHANGE]
		&& cfg[smbus_alert_pkg::CFG_PIN1_EN]);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cfg <= smbus_alert_pkg::CFG_RST;
		end else if (wr_cfg) begin
			cfg <= req.data & smbus_alert_pkg::CFG_WMASK;
		end
	end

	// set wins over a clear arriving in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			notify <= 1'b0;
		end else begin
			notify <= trig | (notify & ~win_evt
				& ~(wr_cfg & ~req.data[smbus_alert_pkg::CFG_NOTIFY]));
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctl <= smbus_alert_pkg::CTL_RST;
		end else if (wr_en && req.ptr == smbus_alert_pkg::REG_CONTROL) begin
			ctl <= req.data & smbus_alert_pkg::CTL_WMASK;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			flt1 <= smbus_alert_pkg::FAULT_RST;
			flt2 <= smbus_alert_pkg::FAULT_RST;
		end else begin
			flt1 <= (wr_en && req.ptr == smbus_alert_pkg::REG_FAULT_LOG_ONE
				? req.data : flt1) | {fault_evt_i.oc, fault_evt_i.uv};
			flt2 <= ((wr_en && req.ptr == smbus_alert_pkg::REG_FAULT_LOG_TWO
				? req.data : flt2) & smbus_alert_pkg::FT2_MASK)
				| {pin_toggle, 3'h0, fault_evt_i.pb};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			gpin <= smbus_alert_pkg::GPIN_RST;
		end else if (wr_gpin) begin
			gpin <= req.data & smbus_alert_pkg::GPIN_WMASK;
		end
	end

	assign gpio_o     = 3'h0;
	assign gpio_oe_o  = gpin[smbus_alert_pkg::GPIN_PULLDOWN_LO +: 3];
	assign meas_sel_o = gpin[smbus_alert_pkg::GPIN_SEL_LO +: 2];
	assign alert_o    = 1'b0;
	assign alert_oe_o = notify;

	// ****************************************
	// checks
	// ****************************************
	a_ptr_hold: assert property (@(posedge link_clk_i) disable iff (lrst)
		$changed(ptr) |-> $past(cmd_load))
		else $error("pointer changed outside a command byte");
	a_cmd_ptr: assert property (@(posedge link_clk_i) disable iff (lrst)
		cmd_load |=> ptr == $past(cmd_low))
		else $error("pointer not loaded from command low bits");
	a_write_data: assert property (@(posedge link_clk_i) disable iff (lrst)
		(byte_end && state == L_WDATA) |=> req.wr && $changed(req_tog)
		&& req.data == $past(shreg) && req.ptr == $past(ptr))
		else $error("first data byte not forwarded");
	a_write_drop: assert property (@(posedge link_clk_i) disable iff (lrst)
		(byte_end && state == L_WDISC) |=> $stable(req_tog) ##1 state == L_ACK)
		else $error("extra data byte not dropped");
	a_arb_lost: assert property (@(posedge link_clk_i) disable iff (lrst)
		(state == L_TX && ara && scl_rise && !sda_drv && !sda_s[1]
		&& !start && !stop) |=> state == L_IDLE && $stable(win_tog))
		else $error("lost arbitration but kept sending");
	a_ara_nack: assert property (@(posedge link_clk_i) disable iff (lrst)
		(byte_end && state == L_ADDR && !notify_s[1]
		&& shreg == {smbus_alert_pkg::ARA_ADDR, 1'b1}) |=> !sda_drv)
		else $error("alert address acked while idle");
	a_word_repeat: assert property (@(posedge link_clk_i) disable iff (lrst)
		(state == L_MACK && scl_fall && more && !ara && !start && !stop)
		|=> state == L_TX && shreg == txbyte)
		else $error("second read byte differs");
	a_notify_set: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		trig |=> alert_oe_o [*2])
		else $error("enabled fault did not pull the line");
	a_sw_release: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(wr_cfg && !req.data[smbus_alert_pkg::CFG_NOTIFY] && !trig)
		|=> !alert_oe_o)
		else $error("zero write did not release the line");
	a_win_release: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(win_evt && !trig) |=> !notify)
		else $error("winner kept the line low");
	a_same_kind: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(|flt1[3:0] && |fault_evt_i.uv && !notify && !pin_toggle
		&& ~|fault_evt_i.oc && ~|fault_evt_i.pb) |=> !notify)
		else $error("notification raised for a logged kind");
	a_pin_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		pin_toggle |=> flt2[smbus_alert_pkg::FT2_PIN1_CHANGE])
		else $error("pin toggle not logged");
	a_pin_out: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		wr_gpin |=> gpio_oe_o == req.data[5:3] && meas_sel_o == req.data[7:6])
		else $error("pin control write not applied");

	c_write: cover property (@(posedge link_clk_i) disable iff (lrst)
		byte_end && state == L_WDATA);
	c_word_read: cover property (@(posedge link_clk_i) disable iff (lrst)
		state == L_MACK && scl_fall && more && !ara);
	c_ara_win: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		win_evt && notify);
	c_pin_alert: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		pin_toggle && trig);
endmodule

// ==== verilog/smbus_alert_pkg.sv ====
// shared constants and types for the serial slave with alert and pins
package smbus_alert_pkg;
	// ****************************************
	// register pointers
	// ****************************************
	localparam logic [4:0] REG_ALERT_CFG           = 5'h00;
	localparam logic [4:0] REG_CONTROL             = 5'h01;
	localparam logic [4:0] REG_FAULT_LOG_ONE       = 5'h02;
	localparam logic [4:0] REG_FAULT_LOG_TWO       = 5'h03;
	localparam logic [4:0] REG_GENERAL_PIN_CONTROL = 5'h04;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CFG_UV_EN        = 0;
	localparam int CFG_OC_EN        = 1;
	localparam int CFG_PB_EN        = 2;
	localparam int CFG_NOTIFY       = 3;
	localparam int CFG_PIN1_EN      = 7;
	localparam int CTL_BCAST_EN     = 5;
	localparam int FT2_PIN1_CHANGE  = 7;
	localparam int GPIN_PULLDOWN_LO = 3;
	localparam int GPIN_SEL_LO      = 6;

	// ****************************************
	// masks and reset values
	// ****************************************
	localparam logic [7:0] CFG_WMASK  = 8'h87;
	localparam logic [7:0] CTL_WMASK  = 8'h20;
	localparam logic [7:0] FT2_MASK   = 8'h8F;
	localparam logic [7:0] GPIN_WMASK = 8'hF8;
	localparam logic [7:0] CFG_RST    = 8'h00;
	localparam logic [7:0] CTL_RST    = 8'h20;
	localparam logic [7:0] FAULT_RST  = 8'h00;
	localparam logic [7:0] GPIN_RST   = 8'h00;

	// ****************************************
	// bus addresses and framing
	// ****************************************
	localparam logic [1:0] ADDR_FIXED_MSBS = 2'h1;
	localparam logic [6:0] BCAST_ADDR      = 7'h17;
	localparam logic [6:0] ARA_ADDR        = 7'h0C;
	localparam logic [3:0] BYTE_BITS       = 4'h8;
	localparam logic [3:0] LAST_BIT        = 4'h7;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [3:0] uv;
		logic [3:0] oc;
		logic [3:0] pb;
	} fault_evt_t;

	typedef struct packed {
		logic       wr;
		logic [4:0] ptr;
		logic [7:0] data;
	} xfer_req_t;
endpackage

// ==== verification/smbus_master_model.sv ====
// bus master model for the two-wire link of the slave
`timescale 1ns/1ps
module smbus_master_model #(
	parameter int HALF_NS = 200
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end

	// ****************************************
	// framing
	// ****************************************
	// also serves as repeated start: scl is low on entry then
	task automatic start();
		sda_pull_o = 1'b0;
		#(HALF_NS / 2);
		scl_pull_o = 1'b0;
		#(HALF_NS);
		sda_pull_o = 1'b1;
		#(HALF_NS / 2);
		scl_pull_o = 1'b1;
		#(HALF_NS / 2);
	endtask

	task automatic stop();
		sda_pull_o = 1'b1;
		#(HALF_NS / 2);
		scl_pull_o = 1'b0;
		#(HALF_NS / 2);
		sda_pull_o = 1'b0;
		#(HALF_NS);
	endtask

	// sample at our own high phase, never at release
	task automatic bit_io(input logic tx, output logic rx);
		int n;
		sda_pull_o = ~tx;
		#(HALF_NS / 2);
		scl_pull_o = 1'b0;
		n = 0;
		// slave may stretch while fetching read data
		while (scl_i !== 1'b1 && n < 500) begin
			#10;
			n++;
		end
		#(HALF_NS / 2);
		rx = sda_i;
		#(HALF_NS / 2);
		scl_pull_o = 1'b1;
		#(HALF_NS / 2);
	endtask

	// msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] tx, input logic ack_bit,
		output logic [7:0] rx, output logic ack_seen);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], b);
			rx[i] = b;
		end
		bit_io(ack_bit, ack_seen);
	endtask
endmodule

// ==== verification/smbus_slave_alert_gpio_bench.sv ====
// self-checking bench for the serial slave with alert and pins
`timescale 1ns/1ps
module smbus_slave_alert_gpio_bench;
	localparam logic [6:0] OWN_ADDR = 7'h36;
	logic                        sys_clk_i = 1'b0;
	logic                        link_clk_i = 1'b0;
	logic                        srst_i = 1'b1;
	logic [4:0]                  strap = 5'h16;
	logic [2:0]                  gpio_in = 3'h0;
	smbus_alert_pkg::fault_evt_t evt = '0;
	logic                        scl;
	logic                        sda;
	logic                        m_scl;
	logic                        m_sda;
	logic                        s_scl_oe;
	logic                        s_sda_oe;
	logic [2:0]                  gpio_oe;
	logic [1:0]                  meas_sel;
	logic                        alert_oe;
	logic                        s_scl;
	logic                        s_sda;
	logic [2:0]                  gpio_lvl;
	logic                        alert_lvl;
	logic [7:0]                  b0;
	logic [7:0]                  b1;
	logic                        ok;
	int                          num_errors = 0;
	int                          samples_checked = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;
	initial begin
		#1.7;
		forever #3 link_clk_i = ~link_clk_i;
	end

	// pulled-up wires: low while either party pulls
	assign scl = ~(m_scl | (s_scl_oe & ~s_scl));
	assign sda = ~(m_sda | (s_sda_oe & ~s_sda));

	smbus_slave_alert_gpio i_dut (
		.sys_clk_i   (sys_clk_i),
		.srst_i      (srst_i),
		.link_clk_i  (link_clk_i),
		.scl_i       (scl),
		.scl_o       (s_scl),
		.scl_oe_o    (s_scl_oe),
		.sda_i       (sda),
		.sda_o       (s_sda),
		.sda_oe_o    (s_sda_oe),
		.addr_strap_i(strap),
		.fault_evt_i (evt),
		.gpio_i      (gpio_in),
		.gpio_o      (gpio_lvl),
		.gpio_oe_o   (gpio_oe),
		.meas_sel_o  (meas_sel),
		.alert_o     (alert_lvl),
		.alert_oe_o  (alert_oe)
	);

	smbus_master_model host (
		.scl_i     (scl),
		.sda_i     (sda),
		.scl_pull_o(m_scl),
		.sda_pull_o(m_sda)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// gap after stop leaves the core time to take the byte
	task automatic wr(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] d, input logic word, output logic ack);
		logic [7:0] rx;
		logic [3:0] k;
		k = 4'h0;
		host.start();
		host.byte_io({a, 1'b0}, 1'b1, rx, k[0]);
		host.byte_io(c, 1'b1, rx, k[1]);
		host.byte_io(d, 1'b1, rx, k[2]);
		if (word)
			host.byte_io(8'h5A, 1'b1, rx, k[3]);
		host.stop();
		ack = (k === 4'h0);
		#1000;
	endtask

	task automatic rd(input logic cmd, input logic [7:0] c,
		input logic word, output logic [7:0] r0, output logic [7:0] r1);
		logic k;
		r1 = 8'h00;
		if (cmd) begin
			host.start();
			host.byte_io({OWN_ADDR, 1'b0}, 1'b1, r0, k);
			host.byte_io(c, 1'b1, r0, k);
		end
		host.start();
		host.byte_io({OWN_ADDR, 1'b1}, 1'b1, r0, k);
		host.byte_io(8'hFF, ~word, r0, k);
		if (word)
			host.byte_io(8'hFF, 1'b1, r1, k);
		host.stop();
	endtask

	// drv zeros stand in for a competing responder
	task automatic ara(input logic [7:0] drv, output logic [7:0] r,
		output logic ack);
		logic k;
		host.start();
		host.byte_io({smbus_alert_pkg::ARA_ADDR, 1'b1}, 1'b1, r, k);
		ack = ~k;
		host.byte_io(drv, 1'b1, r, k);
		host.stop();
		repeat (8) @(negedge sys_clk_i);
	endtask

	// pattern is {uv, oc, pb}, one nibble per kind
	task automatic evt_pulse(input logic [11:0] e);
		@(negedge sys_clk_i);
		evt = e;
		@(negedge sys_clk_i);
		evt = '0;
		repeat (4) @(negedge sys_clk_i);
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20) @(negedge sys_clk_i);
		srst_i = 1'b0;
		#500;
		wr(OWN_ADDR, 8'hE4, 8'hCA, 1'b1, ok);
		check("write ack", 8'(ok), 8'h01);
		check("pulldowns", 8'(gpio_oe), 8'h01);
		check("meas select", 8'(meas_sel), 8'h03);
		@(negedge sys_clk_i);
		gpio_in = 3'h5;
		repeat (4) @(negedge sys_clk_i);
		rd(1'b1, 8'h04, 1'b1, b0, b1);
		check("pin reg", b0, 8'hCD);
		check("second byte", b1, 8'hCD);
		rd(1'b0, 8'h00, 1'b0, b0, b1);
		check("reread", b0, 8'hCD);
		wr(7'h16, 8'h04, 8'h00, 1'b0, ok);
		check("bad addr", 8'(ok), 8'h00);
		wr(smbus_alert_pkg::BCAST_ADDR, 8'h04, 8'h30, 1'b0, ok);
		check("bcast ack", 8'(ok), 8'h01);
		check("bcast data", 8'(gpio_oe), 8'h06);
		wr(OWN_ADDR, 8'h01, 8'h00, 1'b0, ok);
		wr(smbus_alert_pkg::BCAST_ADDR, 8'h04, 8'h00, 1'b0, ok);
		check("bcast masked", 8'(ok), 8'h00);
		check("oe kept", 8'(gpio_oe), 8'h06);
		ara(8'hFF, b0, ok);
		check("quiet ara", 8'(ok), 8'h00);
		wr(OWN_ADDR, 8'h00, 8'h01, 1'b0, ok);
		evt_pulse(12'h100);
		check("alert", 8'(alert_oe), 8'h01);
		rd(1'b1, 8'h00, 1'b0, b0, b1);
		check("flag", b0, 8'h09);
		ara(8'h42, b0, ok);
		check("lost byte", b0, 8'h42);
		check("loser holds", 8'(alert_oe), 8'h01);
		ara(8'hFF, b0, ok);
		check("ara ack", 8'(ok), 8'h01);
		check("ara addr", b0, {2'h1, strap, 1'b0});
		check("winner lets go", 8'(alert_oe), 8'h00);
		evt_pulse(12'h200);
		check("same kind", 8'(alert_oe), 8'h00);
		evt_pulse(12'h100);
		check("persisting", 8'(alert_oe), 8'h00);
		wr(OWN_ADDR, 8'h02, 8'h00, 1'b0, ok);
		evt_pulse(12'h100);
		check("rearmed", 8'(alert_oe), 8'h01);
		wr(OWN_ADDR, 8'h00, 8'h01, 1'b0, ok);
		check("sw release", 8'(alert_oe), 8'h00);
		wr(OWN_ADDR, 8'h00, 8'h02, 1'b0, ok);
		evt_pulse(12'h010);
		check("other kind", 8'(alert_oe), 8'h01);
		rd(1'b1, 8'h02, 1'b0, b0, b1);
		check("fault log one", b0, 8'h11);
		wr(OWN_ADDR, 8'h03, 8'h00, 1'b0, ok);
		wr(OWN_ADDR, 8'h00, 8'h80, 1'b0, ok);
		@(negedge sys_clk_i);
		gpio_in = 3'h4;
		repeat (6) @(negedge sys_clk_i);
		check("pin alert", 8'(alert_oe), 8'h01);
		check("drive levels", 8'({alert_lvl, gpio_lvl}), 8'h00);
		rd(1'b1, 8'h03, 1'b0, b0, b1);
		check("change flag", b0, 8'h80);
		test_done();
	end

	// whole sequence needs well under a millisecond
	initial begin
		#2_000_000;
		num_errors++;
		test_done();
	end
endmodule
